// ### common/psetrg_map.svh
// register offsets, field positions, reset values and timing for trigger regs
`ifndef PSETRG_MAP_SVH
`define PSETRG_MAP_SVH
`define PSETRG_OFF_GEN_EN 8'h0F
`define PSETRG_OFF_DETCLS 8'h10
`define PSETRG_OFF_PWR 8'h11
`define PSETRG_OFF_LEGACY 8'h12
`define PSETRG_BIT_PWR_LIMIT 2
`define PSETRG_BIT_CONV 1
`define PSETRG_BIT_WDOG 0
`define PSETRG_HI_NIB 4
`define PSETRG_RST_BYTE 8'h00
`define PSETRG_RST_CONV 1'b1
`define PSETRG_RST_WDOG 1'b0
`define PSETRG_RST_LEG 2'b00
`define PSETRG_STRAP_SETTLE 3'h4
`define PSETRG_HOLD_MS 400
`define PSETRG_CLK_KHZ 200000
`define PSETRG_HOLD_CYC (`PSETRG_HOLD_MS * `PSETRG_CLK_KHZ)
`endif

// ### common/psetrg_pkg.sv
// types shared by the trigger register bank
package psetrg_pkg;
   typedef enum logic [1:0] {
      PSETRG_MODE_MANUAL,
      PSETRG_MODE_SEMI,
      PSETRG_MODE_AUTO,
      PSETRG_MODE_OFF
   } psetrg_mode_t;
   typedef enum logic [1:0] {
      PSETRG_LEG_OFF,
      PSETRG_LEG_ONLY,
      PSETRG_LEG_AFTER,
      PSETRG_LEG_RSVD
   } psetrg_leg_t;
endpackage

// ### src/psetrg_regs.sv
// trigger, enable and legacy-select registers of the four-port power source
`timescale 1ns/1ps
`include "psetrg_map.svh"
module psetrg_regs #(
   parameter int NPORT = 4,
   parameter int HOLD_CYC = `PSETRG_HOLD_CYC
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // register access from the management bus decoder
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // strap and power ceiling pins
   input wire logic auto_strap_pin,
   input wire logic power_ceiling_pin,
   // operating mode and per-port enables
   input wire psetrg_pkg::psetrg_mode_t op_mode,
   input wire logic [3:0] detect_enable,
   input wire logic [3:0] classify_enable,
   // per-port engine status
   input wire logic [3:0] detect_done,
   input wire logic [3:0] classify_done,
   input wire logic [3:0] startup_done,
   input wire logic [3:0] port_off_done,
   input wire logic [3:0] results_valid,
   input wire logic [3:0] port_powered,
   input wire logic [3:0] port_shutdown,
   input wire logic [3:0] legacy_active,
   input wire logic [3:0] port_fail,
   // control to engines
   output logic total_power_limit_en,
   output logic converter_en,
   output logic bus_watchdog_en,
   output logic power_limit_shutdown,
   output logic [3:0] detect_run,
   output logic [3:0] classify_run,
   output logic [3:0] port_power_up,
   output logic [3:0] port_power_down,
   output logic [3:0] legacy_run,
   output logic [3:0] standard_detect_off
);
   logic [2:0] sync_strap_ff;
   logic [2:0] sync_ceil_ff;
   logic strap_ff;
   logic ceil_ff;
   logic strap_taken_ff;
   logic [2:0] strap_wait_ff;
   logic [3:0] redetect_trigger_ff;
   logic [3:0] reclassify_trigger_ff;
   logic [3:0] port_start_trigger_ff;
   logic [3:0] port_off_trigger_ff;
   logic [3:0] pending_detect_ff;
   logic [7:0] legacy_select_ff;
   logic [7:0] rdata_ff;
   logic [31:0] hold_cnt_ff [NPORT];
   logic wr_gen;
   logic wr_dc;
   logic wr_pwr;
   logic wr_leg;
   logic [3:0] pon_allow;
   logic [3:0] pon_drop;

   assign wr_gen = reg_wr && reg_addr == `PSETRG_OFF_GEN_EN;
   assign wr_dc = reg_wr && reg_addr == `PSETRG_OFF_DETCLS;
   assign wr_pwr = reg_wr && reg_addr == `PSETRG_OFF_PWR;
   assign wr_leg = reg_wr && reg_addr == `PSETRG_OFF_LEGACY;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers: change counts when stages two and three agree
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sync_strap_ff <= 3'h0;
         sync_ceil_ff <= 3'h0;
         strap_ff <= 1'b0;
         ceil_ff <= 1'b0;
      end else begin
         sync_strap_ff <= {sync_strap_ff[1:0], auto_strap_pin};
         sync_ceil_ff <= {sync_ceil_ff[1:0], power_ceiling_pin};
         if (sync_strap_ff[1] == sync_strap_ff[2]) begin
            strap_ff <= sync_strap_ff[2];
         end
         if (sync_ceil_ff[1] == sync_ceil_ff[2]) begin
            ceil_ff <= sync_ceil_ff[2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // strap settle: the synchroniser shows reset zeros for its first edges,
   // so the strap level is trusted only once the filter stage has seen it
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         strap_wait_ff <= 3'h0;
      end else if (strap_wait_ff != `PSETRG_STRAP_SETTLE) begin
         strap_wait_ff <= strap_wait_ff + 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // general enable register
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         total_power_limit_en <= 1'b0;
         converter_en <= `PSETRG_RST_CONV;
         bus_watchdog_en <= `PSETRG_RST_WDOG;
         strap_taken_ff <= 1'b0;
      end else begin
         // taken once after reset; later only writes change the bit
         if (!strap_taken_ff && strap_wait_ff == `PSETRG_STRAP_SETTLE) begin
            strap_taken_ff <= 1'b1;
            total_power_limit_en <= strap_ff;
         end
         // a write in the capture cycle wins over the strap
         if (wr_gen) begin
            total_power_limit_en <= reg_wdata[`PSETRG_BIT_PWR_LIMIT];
            converter_en <= reg_wdata[`PSETRG_BIT_CONV];
            bus_watchdog_en <= reg_wdata[`PSETRG_BIT_WDOG];
         end
      end
   end

   // shutdown request while limit enabled and ceiling reached
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         power_limit_shutdown <= 1'b0;
      end else begin
         power_limit_shutdown <= total_power_limit_en && ceil_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // power-on qualification per mode and 400 ms hold timers
   always_comb begin
      for (int i = 0; i < NPORT; i++) begin
         case (op_mode)
            psetrg_pkg::PSETRG_MODE_MANUAL: begin
               pon_allow[i] = !port_powered[i] && !port_shutdown[i];
            end
            psetrg_pkg::PSETRG_MODE_SEMI: begin
               pon_allow[i] = results_valid[i];
            end
            psetrg_pkg::PSETRG_MODE_AUTO: begin
               pon_allow[i] = legacy_active[i];
            end
            default: begin
               // off mode code: no port may be powered up
               pon_allow[i] = 1'b0;
            end
         endcase
      end
   end

   // a failure or an over-long hold drops the start request
   always_comb begin
      for (int i = 0; i < NPORT; i++) begin
         // fail may be a single pulse; one is enough
         pon_drop[i] = port_fail[i] ||
            (hold_cnt_ff[i] >= 32'(HOLD_CYC - 1));
      end
   end

   genvar g;
   generate
      for (g = 0; g < NPORT; g++) begin : g_hold
         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               hold_cnt_ff[g] <= 32'h0;
            end else if (port_start_trigger_ff[g] && port_powered[g]) begin
               hold_cnt_ff[g] <= hold_cnt_ff[g] + 32'h1;
            end else begin
               hold_cnt_ff[g] <= 32'h0;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // redetect triggers; completion clears unless a new write sets
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         redetect_trigger_ff <= 4'h0;
      end else begin
         redetect_trigger_ff <= (redetect_trigger_ff & ~detect_done) |
            (wr_dc ? reg_wdata[3:0] : 4'h0);
      end
   end

   // reclassify triggers; a write in the done cycle keeps the bit set
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         reclassify_trigger_ff <= 4'h0;
      end else begin
         reclassify_trigger_ff <= (reclassify_trigger_ff & ~classify_done) |
            (wr_dc ? reg_wdata[7:4] : 4'h0);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // power-off triggers clear on the off engine's done pulse
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         port_off_trigger_ff <= 4'h0;
      end else begin
         port_off_trigger_ff <= (port_off_trigger_ff & ~port_off_done) |
            (wr_pwr ? reg_wdata[7:4] : 4'h0);
      end
   end

   // power-on triggers clear on start-up done, a failure or hold expiry
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         port_start_trigger_ff <= 4'h0;
      end else begin
         port_start_trigger_ff <= (port_start_trigger_ff &
            ~(startup_done | pon_drop)) |
            (wr_pwr ? reg_wdata[3:0] : 4'h0);
      end
   end

   // start written with detect enabled: detection must finish first
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pending_detect_ff <= 4'h0;
      end else begin
         pending_detect_ff <= (pending_detect_ff & ~detect_done &
            ~pon_drop) |
            (wr_pwr ? reg_wdata[3:0] & detect_enable : 4'h0);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // legacy select
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         legacy_select_ff <= {4{`PSETRG_RST_LEG}};
      end else if (wr_leg) begin
         legacy_select_ff <= reg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // legacy decode; the reserved code behaves as disabled
   always_comb begin
      for (int i = 0; i < NPORT; i++) begin
         case (psetrg_pkg::psetrg_leg_t'(legacy_select_ff[2*i +: 2]))
            psetrg_pkg::PSETRG_LEG_ONLY: begin
               legacy_run[i] = 1'b1;
               standard_detect_off[i] = 1'b1;
            end
            psetrg_pkg::PSETRG_LEG_AFTER: begin
               // follows each standard detect completion
               legacy_run[i] = detect_done[i];
               standard_detect_off[i] = 1'b0;
            end
            default: begin
               legacy_run[i] = 1'b0;
               standard_detect_off[i] = 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // detect and classify requests; manual mode runs only on a trigger
   always_comb begin
      for (int i = 0; i < NPORT; i++) begin
         if (op_mode == psetrg_pkg::PSETRG_MODE_MANUAL) begin
            detect_run[i] = redetect_trigger_ff[i] |
               pending_detect_ff[i];
            classify_run[i] = reclassify_trigger_ff[i];
         end else begin
            detect_run[i] = detect_enable[i] | redetect_trigger_ff[i] |
               pending_detect_ff[i];
            classify_run[i] = classify_enable[i] |
               reclassify_trigger_ff[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // power requests; an off request always overrides power-up
   always_comb begin
      for (int i = 0; i < NPORT; i++) begin
         // power-up waits for any detect pending from the same write
         port_power_up[i] = port_start_trigger_ff[i] && pon_allow[i] &&
            !pending_detect_ff[i] && !port_off_trigger_ff[i];
         port_power_down[i] = port_off_trigger_ff[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data, registered one edge after the address is presented
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rdata_ff <= `PSETRG_RST_BYTE;
      end else begin
         case (reg_addr)
            `PSETRG_OFF_GEN_EN: begin
               rdata_ff <= {5'h00, total_power_limit_en, converter_en,
                  bus_watchdog_en};
            end
            `PSETRG_OFF_DETCLS: begin
               rdata_ff <= {reclassify_trigger_ff, redetect_trigger_ff};
            end
            `PSETRG_OFF_PWR: begin
               rdata_ff <= {port_off_trigger_ff, port_start_trigger_ff};
            end
            `PSETRG_OFF_LEGACY: begin
               rdata_ff <= legacy_select_ff;
            end
            default: begin
               // unmapped offsets read as zero
               rdata_ff <= `PSETRG_RST_BYTE;
            end
         endcase
      end
   end

   assign reg_rdata = rdata_ff;
endmodule

// ### bench/psetrg_regs_monitor.sv
// assertions on the trigger register bank ports
`timescale 1ns/1ps
module psetrg_regs_monitor (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // register access
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // mode and port status
   input wire psetrg_pkg::psetrg_mode_t op_mode,
   input wire logic [3:0] results_valid,
   input wire logic [3:0] port_powered,
   input wire logic [3:0] port_shutdown,
   input wire logic [3:0] legacy_active,
   input wire logic [3:0] classify_done,
   // controls
   input wire logic total_power_limit_en,
   input wire logic converter_en,
   input wire logic bus_watchdog_en,
   input wire logic power_limit_shutdown,
   input wire logic [3:0] classify_run,
   input wire logic [3:0] port_power_up,
   input wire logic [3:0] port_power_down
);
   logic [2:0] wd_ff;
   wire gen_sel = reg_addr == 8'h0F;
   wire [2:0] gen = {total_power_limit_en, converter_en, bus_watchdog_en};
   wire man = op_mode == psetrg_pkg::PSETRG_MODE_MANUAL;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wd_ff <= 3'h0;
      end else begin
         wd_ff <= reg_wdata[2:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   a_gen_write: assert property (reg_wr && gen_sel |=> gen == wd_ff)
      else $error("enable bits differ from write");
   a_limit_gate: assert property (
      power_limit_shutdown |-> $past(total_power_limit_en))
      else $error("shutdown without enable");
   a_gen_rsvd: assert property (gen_sel |=> reg_rdata[7:3] == 5'h00)
      else $error("reserved bits read nonzero");
   a_manual_up: assert property (man |->
      (port_power_up & (port_powered | port_shutdown)) == 4'h0)
      else $error("power up on busy port");
   a_semi_up: assert property (
      op_mode == psetrg_pkg::PSETRG_MODE_SEMI |->
      (port_power_up & ~results_valid) == 4'h0)
      else $error("power up without valid results");
   a_auto_up: assert property (
      op_mode == psetrg_pkg::PSETRG_MODE_AUTO |->
      (port_power_up & ~legacy_active) == 4'h0)
      else $error("power up outside legacy detect");
   a_off_wins: assert property ((port_power_up & port_power_down) == 4'h0)
      else $error("power up and down together");
   a_cls_clear: assert property ((man && !reg_wr) ##1 man |->
      (classify_run & $past(classify_done)) == 4'h0)
      else $error("reclassify bit kept after done");
endmodule

// ### bench/psetrg_engine_model.sv
// behavioural detect, classify and power engines beside the registers
`timescale 1ns/1ps
module psetrg_engine_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // stall from the bench
   input wire logic hold,
   // requests
   input wire logic [3:0] detect_run,
   input wire logic [3:0] classify_run,
   input wire logic [3:0] port_power_up,
   input wire logic [3:0] port_power_down,
   // completions and port state
   output logic [3:0] detect_done,
   output logic [3:0] classify_done,
   output logic [3:0] startup_done,
   output logic [3:0] port_off_done,
   output logic [3:0] port_powered
);
   wire [3:0] go = {4{!hold}};
   // done is one cycle long; a request held high completes every other cycle
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         {detect_done, classify_done, startup_done} <= 12'h000;
         {port_off_done, port_powered} <= 8'h00;
      end else begin
         detect_done <= detect_run & ~detect_done & go;
         classify_done <= classify_run & ~classify_done & go;
         startup_done <= port_power_up & ~startup_done & go;
         port_off_done <= port_power_down & ~port_off_done & go;
         port_powered <= (port_powered | startup_done) & ~port_off_done;
      end
   end
endmodule

// ### bench/test_pse_port_trigger_enable_regs.sv
// self-checking bench for the trigger register bank
`timescale 1ns/1ps
module test_pse_port_trigger_enable_regs;
   logic clk_sys = 0, resetn = 0, reg_wr = 0, hold = 1;
   logic auto_strap_pin = 1, power_ceiling_pin = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   psetrg_pkg::psetrg_mode_t op_mode = psetrg_pkg::PSETRG_MODE_MANUAL;
   logic [3:0] detect_enable = 0, classify_enable = 0, results_valid = 0;
   logic [3:0] port_shutdown = 0, legacy_active = 0, port_fail = 0;
   logic [3:0] detect_done, classify_done, startup_done, port_off_done;
   logic [3:0] port_powered, detect_run, classify_run, port_power_up;
   logic [3:0] port_power_down, legacy_run, standard_detect_off;
   logic total_power_limit_en, converter_en, bus_watchdog_en;
   logic power_limit_shutdown;
   int bad_count = 0, n_checks = 0;
   psetrg_regs #(.HOLD_CYC(20)) i_dut (.*);
   psetrg_engine_model i_eng (.*);
   initial forever #2.5 clk_sys = ~clk_sys;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr = 1;
      reg_addr = a;
      reg_wdata = d;
      cyc(1);
      reg_wr = 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      reg_addr = a;
      cyc(1);
      chk(reg_rdata, exp);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_gen;
      rd(8'h0F, 8'h06);
      rd(8'h10, 8'h00);
      rd(8'h11, 8'h00);
      rd(8'h12, 8'h00);
      rd(8'h13, 8'h00);
      wr(8'h0F, 8'hFF);
      rd(8'h0F, 8'h07);
      power_ceiling_pin = 1;
      cyc(5);
      chk(8'(power_limit_shutdown), 8'h01);
      wr(8'h0F, 8'h02);
      cyc(2);
      chk(8'(power_limit_shutdown), 8'h00);
      auto_strap_pin = 0;
      resetn = 0;
      cyc(2);
      resetn = 1;
      cyc(5);
      rd(8'h0F, 8'h02);
   endtask
   task automatic t_legacy;
      wr(8'h12, 8'hE4);
      rd(8'h12, 8'hE4);
      chk(8'(standard_detect_off), 8'h02);
      chk(8'(legacy_run), 8'h02);
      wr(8'h12, 8'h00);
      cyc(1);
   endtask
   task automatic t_det;
      wr(8'h10, 8'h81);
      chk({classify_run, detect_run}, 8'h81);
      hold = 0;
      cyc(4);
      rd(8'h10, 8'h00);
      hold = 1;
   endtask
   task automatic t_pwr;
      wr(8'h11, 8'h01);
      chk(8'(port_power_up), 8'h01);
      hold = 0;
      cyc(4);
      rd(8'h11, 8'h00);
      hold = 1;
      wr(8'h11, 8'h01);
      chk(8'(port_power_up), 8'h00);
      cyc(25);
      rd(8'h11, 8'h00);
      wr(8'h11, 8'h11);
      chk({port_power_down, port_power_up}, 8'h10);
      hold = 0;
      cyc(2);
      chk(8'(port_powered), 8'h00);
      cyc(2);
      rd(8'h11, 8'h00);
      chk(8'(port_powered), 8'h01);
      hold = 1;
   endtask
   task automatic t_semi;
      op_mode = psetrg_pkg::PSETRG_MODE_SEMI;
      detect_enable = 4'h2;
      results_valid = 4'h2;
      wr(8'h11, 8'h02);
      chk({detect_run, port_power_up}, 8'h20);
      hold = 0;
      cyc(6);
      chk(8'(port_powered & 4'h2), 8'h02);
      hold = 1;
      detect_enable = 4'h0;
      wr(8'h11, 8'h04);
      chk(8'(port_power_up), 8'h00);
      results_valid = 4'h6;
      op_mode = psetrg_pkg::PSETRG_MODE_AUTO;
      cyc(1);
      chk(8'(port_power_up), 8'h00);
      legacy_active = 4'h4;
      cyc(1);
      chk(8'(port_power_up), 8'h04);
   endtask
   initial begin
      cyc(2);
      resetn = 1;
      cyc(5);
      t_gen;
      t_legacy;
      t_det;
      t_pwr;
      t_semi;
      report_and_stop;
   end
   initial begin
      #5000;
      bad_count++;
      report_and_stop;
   end
endmodule
bind psetrg_regs psetrg_regs_monitor i_mon (.*);
